// *** svm_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module svm_ctrl
    import svm_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        cmp_below_i,
    input  wire logic        sleep_i,
    input  wire logic        idle_i,
    input  wire logic        nvm_write_event_i,
    output logic             monitor_power_o,
    output logic [2:0]       trip_level_select_o,
    output logic [12:0]      trip_voltage_mv_o,
    output logic             mf2_request_o,
    output logic             cpu_irq_o,
    output logic             wake_o,
    output logic             irq_o
);

    // ********************************
    // Bus slave
    // ********************************
    logic        aw_hold_q;
    logic [7:0]  awaddr_q;
    logic        w_hold_q;
    logic [31:0] wdata_q;
    logic        wstrb0_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        do_wr;
    logic        wr_ok;
    logic        rd_hit;
    logic [31:0] rd_mux;

    assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_o  = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;
    assign do_wr = aw_hold_q && w_hold_q;
    assign wr_ok = (awaddr_q == OFF_CTRL) || (awaddr_q == OFF_MF2) || (awaddr_q == OFF_GIE)
                || (awaddr_q == OFF_STAT) || (awaddr_q == OFF_MASK);

    // Address and data may arrive in either order
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 8'h00;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb0_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_i;
            end else if (do_wr) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata_i;
                wstrb0_q <= s_axi_wstrb_i[0];
            end else if (do_wr) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OK;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register write strobes; only byte lane 0 carries register bits
    logic wr_ctrl;
    logic wr_mfi;
    logic wr_gie;
    logic wr_stat;
    logic wr_mask;
    assign wr_ctrl = do_wr && wstrb0_q && (awaddr_q == OFF_CTRL);
    assign wr_mfi  = do_wr && wstrb0_q && (awaddr_q == OFF_MF2);
    assign wr_gie  = do_wr && wstrb0_q && (awaddr_q == OFF_GIE);
    assign wr_stat = do_wr && wstrb0_q && (awaddr_q == OFF_STAT);
    assign wr_mask = do_wr && wstrb0_q && (awaddr_q == OFF_MASK);

    // ********************************
    // Control registers
    // ********************************
    svm_ctrl_t   ctrl_q;
    svm_mfi_t    mfi_q;
    logic        gie_q;
    logic [EV_W-1:0] mask_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= '{en: 1'b0, lvl: RST_LVL};
        end else if (wr_ctrl) begin
            ctrl_q.en  <= wdata_q[CTRL_EN_BIT];
            ctrl_q.lvl <= wdata_q[CTRL_LVL_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gie_q  <= 1'b0;
            mask_q <= 3'h0;
        end else begin
            if (wr_gie) begin
                gie_q <= wdata_q[GIE_BIT];
            end
            if (wr_mask) begin
                mask_q <= wdata_q[EV_W-1:0];
            end
        end
    end

    // ********************************
    // Detector power and result
    // ********************************
    logic cmp_meta_q;
    logic cmp_sync_q;
    logic uv_q;
    logic uv_prev_q;
    logic powered;

    assign powered = ctrl_q.en && !sleep_i;
    assign monitor_power_o     = powered;
    assign trip_level_select_o = ctrl_q.lvl;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_below_i;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Result follows comparator freely; toggling near the level is passed on
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uv_q      <= 1'b0;
            uv_prev_q <= 1'b0;
            trip_voltage_mv_o <= 13'h0000;
        end else begin
            uv_q      <= powered && cmp_sync_q;
            uv_prev_q <= uv_q;
            trip_voltage_mv_o <= svm_trip_mv(ctrl_q.lvl);
        end
    end

    // Settle tracking, a hint for software polling
    logic [CNT_W-1:0] settle_cnt_q;
    logic             settled_q;
    logic             settle_ev;
    assign settle_ev = powered && !settled_q && (settle_cnt_q == CNT_W'(SETTLE_CYC - 1));

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle_cnt_q <= '0;
            settled_q    <= 1'b0;
        end else if (!powered) begin
            settle_cnt_q <= '0;
            settled_q    <= 1'b0;
        end else if (settle_ev) begin
            settled_q <= 1'b1;
        end else if (!settled_q) begin
            settle_cnt_q <= settle_cnt_q + 1'b1;
        end
    end

    // ********************************
    // Raise delay
    // ********************************
    svm_state_t       state_q;
    logic [CNT_W-1:0] cnt_q;
    logic             fire;

    assign fire = (state_q == ST_COUNT) && uv_q && (cnt_q == CNT_W'(RAISE_CYC - 1));

    // A drop before the delay ends restarts the wait
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_WAIT;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ST_WAIT: begin
                    cnt_q <= '0;
                    if (uv_q) begin
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (!uv_q) begin
                        state_q <= ST_WAIT;
                    end else if (fire) begin
                        state_q <= ST_FIRED;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_FIRED: begin
                    if (!uv_q) begin
                        state_q <= ST_WAIT;
                    end
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end

    // ********************************
    // Multi-function request register
    // ********************************
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mfi_q <= '{nwf: 1'b0, uvf: 1'b0, nwe: 1'b0, uve: 1'b0};
        end else begin
            if (wr_mfi) begin
                mfi_q.uve <= wdata_q[MFI_UVE_BIT];
                mfi_q.nwe <= wdata_q[MFI_NWE_BIT];
            end
            // Hardware set wins over a same-cycle write
            if (fire) begin
                mfi_q.uvf <= 1'b1;
            end else if (wr_mfi) begin
                mfi_q.uvf <= wdata_q[MFI_UVF_BIT];
            end
            if (nvm_write_event_i) begin
                mfi_q.nwf <= 1'b1;
            end else if (wr_mfi) begin
                mfi_q.nwf <= wdata_q[MFI_NWF_BIT];
            end
        end
    end

    // Shared source: detector and NVM share one request line
    assign mf2_request_o = (mfi_q.uvf && mfi_q.uve) || (mfi_q.nwf && mfi_q.nwe);
    assign cpu_irq_o     = gie_q && mf2_request_o;

    // Only a fresh flag rise wakes; a preset flag gives none
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= idle_i && fire && !mfi_q.uvf && mfi_q.uve;
        end
    end

    // ********************************
    // Event status and interrupt
    // ********************************
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] ev;
    assign ev[EV_RISE_BIT] = uv_q && !uv_prev_q;
    assign ev[EV_FIRE_BIT] = fire;
    assign ev[EV_SET_BIT]  = settle_ev;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_q <= 3'h0;
        end else if (wr_stat) begin
            stat_q <= (stat_q & ~wdata_q[EV_W-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    assign irq_o = |(stat_q & mask_q);

    // ********************************
    // Read path
    // ********************************
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr_i)
            OFF_CTRL: begin
                rd_mux[CTRL_OUT_BIT]      = uv_q;
                rd_mux[CTRL_EN_BIT]       = ctrl_q.en;
                rd_mux[CTRL_LVL_LSB +: 3] = ctrl_q.lvl;
            end
            OFF_MF2: begin
                rd_mux[MFI_NWF_BIT] = mfi_q.nwf;
                rd_mux[MFI_UVF_BIT] = mfi_q.uvf;
                rd_mux[MFI_NWE_BIT] = mfi_q.nwe;
                rd_mux[MFI_UVE_BIT] = mfi_q.uve;
            end
            OFF_GIE:  rd_mux[GIE_BIT] = gie_q;
            OFF_STAT: rd_mux[EV_W-1:0] = stat_q;
            OFF_MASK: rd_mux[EV_W-1:0] = mask_q;
            default:  rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OK;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? RESP_OK : RESP_ERR;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    logic [CNT_W-1:0] uv_run_q;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uv_run_q <= '0;
        end else if (!uv_q) begin
            uv_run_q <= '0;
        end else if (uv_run_q != '1) begin
            uv_run_q <= uv_run_q + 1'b1;
        end
    end

    sequence s_fire_seen;
        fire && !wr_mfi;
    endsequence
    sequence s_flag_up;
        ##1 mfi_q.uvf;
    endsequence

    a_power_off_asleep: assert property (sleep_i |-> !monitor_power_o)
        else $error("detector powered in sleep");
    a_power_on_enable: assert property ($rose(ctrl_q.en) && !sleep_i |-> monitor_power_o)
        else $error("detector not powered when enabled");
    // Skip the edge right after reset, when the millivolt register still held its reset value of zero
    a_trip_mv_table: assert property ($past(resetn_i)
        |-> trip_voltage_mv_o == svm_trip_mv($past(trip_level_select_o)))
        else $error("trip level table mismatch");
    a_result_unpowered: assert property (!monitor_power_o |=> !uv_q)
        else $error("result high while detector off");
    a_raise_delay: assert property (fire |-> uv_run_q >= CNT_W'(RAISE_CYC))
        else $error("request flag raised too early");
    a_flag_after_fire: assert property (s_fire_seen |-> s_flag_up)
        else $error("request flag not set after delay");
    a_shared_request: assert property (mfi_q.uvf && mfi_q.uve |-> mf2_request_o)
        else $error("set flag gave no request");
    a_global_gate: assert property (cpu_irq_o |-> gie_q && mf2_request_o)
        else $error("interrupt forwarded while disabled");
    a_flag_write: assert property (wr_mfi && !fire && !wdata_q[MFI_UVF_BIT] |=> !mfi_q.uvf)
        else $error("flag write ignored");
    a_wake_fresh: assert property (wake_o |-> $past(idle_i) && !$past(mfi_q.uvf) && mfi_q.uvf)
        else $error("wake without fresh flag rise");

endmodule // svm_ctrl
`default_nettype wire

// *** svm_pkg.sv ***
// Function
// - Power detector only while enable bit set
// - Three-bit code picks one of eight levels
// - Bit 5 reads detector result, read-only
// - Sleep forces detector off regardless of enable
// - Result may toggle near trip level
// - Request flag set after delay past rise
// - Set flag raises request, result still pollable
// - Request routed through shared multi-function source
// - Flag rise wakes from idle; preset flag blocks
// - CPU interrupt not forwarded unless global enable set
package svm_pkg;
    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MF2  = 8'h04;
    localparam logic [7:0] OFF_GIE  = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam int CTRL_LVL_LSB = 0;
    localparam int CTRL_EN_BIT  = 4;
    localparam int CTRL_OUT_BIT = 5;
    localparam int MFI_UVE_BIT  = 0;
    localparam int MFI_NWE_BIT  = 1;
    localparam int MFI_UVF_BIT  = 4;
    localparam int MFI_NWF_BIT  = 5;
    localparam int GIE_BIT      = 0;
    localparam int EV_RISE_BIT  = 0;
    localparam int EV_FIRE_BIT  = 1;
    localparam int EV_SET_BIT   = 2;
    localparam int EV_W         = 3;
    localparam logic [2:0] RST_LVL  = 3'h0;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ********************************
    // Timing
    // ********************************
    localparam int CLK_NS    = 20;
    localparam int SETTLE_NS = 15000;
    localparam int RAISE_NS  = 45000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAISE_CYC  = (RAISE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 12;
    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic       en;
        logic [2:0] lvl;
    } svm_ctrl_t;
    typedef struct packed {
        logic nwf;
        logic uvf;
        logic nwe;
        logic uve;
    } svm_mfi_t;
    typedef enum logic [1:0] {
        ST_WAIT  = 2'h0,
        ST_COUNT = 2'h1,
        ST_FIRED = 2'h3
    } svm_state_t;
    // Trip levels in millivolts, ascending with the code
    function automatic logic [12:0] svm_trip_mv(input logic [2:0] c);
        case (c)
            3'h0: svm_trip_mv = 13'h0708;
            3'h1: svm_trip_mv = 13'h07D0;
            3'h2: svm_trip_mv = 13'h0960;
            3'h3: svm_trip_mv = 13'h0A8C;
            3'h4: svm_trip_mv = 13'h0BB8;
            3'h5: svm_trip_mv = 13'h0CE4;
            3'h6: svm_trip_mv = 13'h0E10;
            default: svm_trip_mv = 13'h0FA0;
        endcase
    endfunction
endpackage

// *** svm_ctrl_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module svm_ctrl_tb
    import svm_pkg::*;
;
    logic        sys_clk_i;
    logic        resetn_i;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        cmp_below;
    logic        sleep;
    logic        idle;
    logic        nvm_ev;
    logic        mon_pwr;
    logic [2:0]  lvl_sel;
    logic [12:0] mv;
    logic        mf2_req;
    logic        cpu_irq;
    logic        wake;
    logic        irq;
    int          fails;
    int          total_checks;
    int          wake_cnt = 0;
    logic [12:0] mv_tab [8] = '{13'h0708, 13'h07D0, 13'h0960, 13'h0A8C, 13'h0BB8, 13'h0CE4, 13'h0E10, 13'h0FA0};

    svm_ctrl u_svm_ctrl (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .cmp_below_i(cmp_below), .sleep_i(sleep), .idle_i(idle), .nvm_write_event_i(nvm_ev),
        .monitor_power_o(mon_pwr), .trip_level_select_o(lvl_sel), .trip_voltage_mv_o(mv),
        .mf2_request_o(mf2_req), .cpu_irq_o(cpu_irq), .wake_o(wake), .irq_o(irq));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // Wake is a one-cycle pulse, so count it rather than poll it
    always @(posedge sys_clk_i) begin
        if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    end

    // ********************************
    // Bus tasks
    // ********************************
    // Ready is looked at on the falling edge; inputs only move after rising edges
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        bit ta;
        bit tw;
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // No local limit: only the watchdog may end a wait
        while (!(aw_done && w_done)) begin
            @(negedge sys_clk_i);
            ta = awvalid & awready;
            tw = wvalid & wready;
            @(posedge sys_clk_i);
            if (ta) begin awvalid <= 1'b0; aw_done = 1; end
            if (tw) begin wvalid <= 1'b0; w_done = 1; end
        end
        @(negedge sys_clk_i);
        while (bvalid !== 1'b1) @(negedge sys_clk_i);
        `CHK(bresp, exp_resp)
        @(posedge sys_clk_i);
        bready <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk,
                          input logic [1:0] exp_resp);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        @(negedge sys_clk_i);
        while (arready !== 1'b1) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        arvalid <= 1'b0;
        @(negedge sys_clk_i);
        while (rvalid !== 1'b1) @(negedge sys_clk_i);
        `CHK(rdata & msk, exp)
        `CHK(rresp, exp_resp)
        @(posedge sys_clk_i);
        rready <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic endtest(input string name);
        $display("test %s done, checks %0d, fails %0d", name, total_checks, fails);
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ********************************
    // Tests
    // ********************************
    initial begin
        resetn_i = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; cmp_below = 1'b0;
        sleep = 1'b0; idle = 1'b0; nvm_ev = 1'b0; fails = 0; total_checks = 0;
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_chk(OFF_CTRL, 32'h0, 32'hFFFF_FFFF, RESP_OK);
        rd_chk(OFF_MF2, 32'h0, 32'hFFFF_FFFF, RESP_OK);
        rd_chk(OFF_GIE, 32'h0, 32'hFFFF_FFFF, RESP_OK);
        rd_chk(8'h20, 32'h0, 32'hFFFF_FFFF, RESP_ERR);
        axi_wr(8'h20, 32'hFF, RESP_ERR);
        `CHK(mon_pwr, 1'b0)
        endtest("reset");
        for (int i = 0; i < 8; i++) begin
            axi_wr(OFF_CTRL, 32'h10 | i, RESP_OK);
            `CHK(lvl_sel, 3'(i))
            `CHK(mv, mv_tab[i])
            `CHK(mon_pwr, 1'b1)
            rd_chk(OFF_CTRL, 32'h10 | i, 32'hFF, RESP_OK);
        end
        axi_wr(OFF_CTRL, 32'h2F, RESP_OK);
        rd_chk(OFF_CTRL, 32'h07, 32'hFF, RESP_OK);
        `CHK(mon_pwr, 1'b0)
        endtest("levels");
        axi_wr(OFF_CTRL, 32'h10, RESP_OK);
        sleep <= 1'b1;
        cmp_below <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        `CHK(mon_pwr, 1'b0)
        rd_chk(OFF_CTRL, 32'h00, 32'h20, RESP_OK);
        cmp_below <= 1'b0;
        sleep <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        `CHK(mon_pwr, 1'b1)
        rd_chk(OFF_STAT, 32'h0, 32'h4, RESP_OK);
        repeat (SETTLE_CYC) @(posedge sys_clk_i);
        rd_chk(OFF_STAT, 32'h4, 32'h4, RESP_OK);
        endtest("sleep");
        axi_wr(OFF_STAT, 32'h07, RESP_OK);
        axi_wr(OFF_MF2, 32'h01, RESP_OK);
        axi_wr(OFF_GIE, 32'h01, RESP_OK);
        axi_wr(OFF_MASK, 32'h02, RESP_OK);
        idle <= 1'b1;
        cmp_below <= 1'b1;
        // A drop before the delay ends must restart it
        repeat (1000) @(posedge sys_clk_i);
        cmp_below <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        `CHK(mf2_req, 1'b0)
        rd_chk(OFF_STAT, 32'h1, 32'h3, RESP_OK);
        cmp_below <= 1'b1;
        repeat (2200) @(posedge sys_clk_i);
        `CHK(mf2_req, 1'b0)
        `CHK(irq, 1'b0)
        rd_chk(OFF_CTRL, 32'h20, 32'h20, RESP_OK);
        repeat (100) @(posedge sys_clk_i);
        `CHK(mf2_req, 1'b1)
        `CHK(cpu_irq, 1'b1)
        `CHK(irq, 1'b1)
        `CHK(wake_cnt, 1)
        rd_chk(OFF_MF2, 32'h11, 32'hFF, RESP_OK);
        rd_chk(OFF_STAT, 32'h3, 32'h7, RESP_OK);
        endtest("interrupt");
        axi_wr(OFF_GIE, 32'h00, RESP_OK);
        `CHK(cpu_irq, 1'b0)
        `CHK(mf2_req, 1'b1)
        axi_wr(OFF_MF2, 32'h10, RESP_OK);
        `CHK(mf2_req, 1'b0)
        axi_wr(OFF_MF2, 32'h00, RESP_OK);
        rd_chk(OFF_MF2, 32'h00, 32'hFF, RESP_OK);
        nvm_ev <= 1'b1;
        @(posedge sys_clk_i);
        nvm_ev <= 1'b0;
        rd_chk(OFF_MF2, 32'h20, 32'hFF, RESP_OK);
        `CHK(mf2_req, 1'b0)
        axi_wr(OFF_MF2, 32'h22, RESP_OK);
        `CHK(mf2_req, 1'b1)
        `CHK(cpu_irq, 1'b0)
        axi_wr(OFF_MF2, 32'h00, RESP_OK);
        axi_wr(OFF_STAT, 32'h03, RESP_OK);
        rd_chk(OFF_STAT, 32'h0, 32'h3, RESP_OK);
        `CHK(irq, 1'b0)
        endtest("gating");
        cmp_below <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        axi_wr(OFF_MF2, 32'h11, RESP_OK);
        axi_wr(OFF_GIE, 32'h01, RESP_OK);
        cmp_below <= 1'b1;
        repeat (2400) @(posedge sys_clk_i);
        `CHK(wake_cnt, 1)
        `CHK(cpu_irq, 1'b1)
        idle <= 1'b0;
        endtest("preset");
        summarize();
    end

    // Whole run is near 7000 cycles; give it a wide margin
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        summarize();
    end
endmodule // svm_ctrl_tb
`default_nettype wire
